//--- include/i2cebc_map.vh
`ifndef I2CEBC_MAP_VH
`define I2CEBC_MAP_VH
// Register byte offsets
`define I2CEBC_MAIN_CTRL 8'h00
`define I2CEBC_FLAG 8'h04
`define I2CEBC_CLK_SEL 8'h08
`define I2CEBC_EXT 8'h0C
`define I2CEBC_STATUS 8'h10
`define I2CEBC_MASK 8'h14
`define I2CEBC_LINES 8'h18
// Main control fields
`define I2CEBC_OPEN_BIT 7
`define I2CEBC_EXIT_BIT 6
`define I2CEBC_SPIE_BIT 4
`define I2CEBC_STRT_BIT 1
`define I2CEBC_STOP_BIT 0
// Flag register fields
`define I2CEBC_BUSY_BIT 6
`define I2CEBC_STWS_BIT 1
`define I2CEBC_RSVD_BIT 0
// Clock select fields
`define I2CEBC_SMC_BIT 3
`define I2CEBC_CLH_BIT 1
`define I2CEBC_CLL_BIT 0
`define I2CEBC_CLX_BIT 0
// Status / mask fields
`define I2CEBC_EV_START 0
`define I2CEBC_EV_STOP 1
`define I2CEBC_EV_REFUSE 2
`define I2CEBC_EV_ACK 3
`define I2CEBC_EV_W 4
// Reset values
`define I2CEBC_CTRL_RST 8'h00
`define I2CEBC_FLAG_RST 8'h00
`define I2CEBC_CSEL_RST 4'h0
// Extension code prefix (top five address bits)
`define I2CEBC_EXT_CODE 5'h1E
// Transfer clock base half period, cycles
`define I2CEBC_DIV_BASE 16'h0040
`endif

//--- verilog/i2cebc_clkdiv.v
`timescale 1ns/1ps
`default_nettype none
`include "i2cebc_map.vh"
// Half-period tick of the transfer clock, from the latched selection.
module i2cebc_clkdiv #(
    parameter [15:0] BASE = `I2CEBC_DIV_BASE
) (
    input wire clk,
    input wire sys_rst,
    input wire run,
    input wire [3:0] sel,
    output reg tick
);
    reg [19:0] cnt;

    function [19:0] div_of;
        input [3:0] s;
        begin
            div_of = {4'h0, BASE} << s[2:0];
            if (s[3])
                div_of = {5'h00, BASE[15:1]};
        end
    endfunction

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt <= 20'h00000;
            tick <= 1'b0;
        end else if (!run) begin
            cnt <= 20'h00000;
            tick <= 1'b0;
        end else if (cnt >= div_of(sel) - 20'h00001) begin
            cnt <= 20'h00000;
            tick <= 1'b1;
        end else begin
            cnt <= cnt + 20'h00001;
            tick <= 1'b0;
        end
    end
endmodule // i2cebc_clkdiv
`default_nettype wire

//--- verilog/i2cebc_ctrl.v
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "i2cebc_map.vh"
// Functional notes
// - Speed mode and two divider bits set the transfer clock; a set extension bit overrides them with half the base half period.
// - Without start-without-stop permit, enabling sets the bus occupied flag.
// - Master start is refused while the bus is regarded as occupied.
// - With start-without-stop permit, enabling clears the bus occupied flag.
// - Enabling with data low and clock high registers a start condition.
// - After a start, an extension code on the bus is acknowledged.
// - Exit communication abandons the slave transfer; no ack follows, but a master side that is not idle keeps driving the lines.
module i2cebc_ctrl #(
    parameter [15:0] DIV_BASE = `I2CEBC_DIV_BASE
) (
    input wire clk,
    input wire sys_rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg irq,
    input wire serial_data_line_i,
    output reg serial_data_line_o,
    output reg serial_data_line_oe,
    input wire serial_clock_line_i,
    output reg serial_clock_line_o,
    output reg serial_clock_line_oe
);
    localparam [1:0] S_IDLE = 2'd0;
    localparam [1:0] S_RX = 2'd1;
    localparam [1:0] S_ACK = 2'd2;
    localparam [1:0] S_EXIT = 2'd3;
    localparam [2:0] M_IDLE = 3'd0;
    localparam [2:0] M_START = 3'd1;
    localparam [2:0] M_HOLD = 3'd2;
    localparam [2:0] M_STOP1 = 3'd3;
    localparam [2:0] M_STOP2 = 3'd4;

    reg [7:0] main_control_reg;
    reg [7:0] flag_reg;
    reg [3:0] clk_sel;
    reg bus_occupied_flag;
    reg [`I2CEBC_EV_W-1:0] status;
    reg [`I2CEBC_EV_W-1:0] mask;
    reg sda_q;
    reg scl_q;
    reg en_q;
    reg [1:0] s_state;
    reg [3:0] bit_cnt;
    reg [7:0] shift;
    reg [2:0] m_state;
    wire tick;

    wire operate_enable = main_control_reg[`I2CEBC_OPEN_BIT];
    wire start_without_stop_permit = flag_reg[`I2CEBC_STWS_BIT];
    wire acc = psel && penable && pready;
    wire wr = acc && pwrite;

    function hit;
        input [7:0] a;
        input [7:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    function mapped;
        input [7:0] a;
        begin
            mapped = hit(a, `I2CEBC_MAIN_CTRL) || hit(a, `I2CEBC_FLAG) ||
                hit(a, `I2CEBC_CLK_SEL) || hit(a, `I2CEBC_EXT) ||
                hit(a, `I2CEBC_STATUS) || hit(a, `I2CEBC_MASK) ||
                hit(a, `I2CEBC_LINES);
        end
    endfunction

    // Line events; pins are sampled directly as synchronous inputs
    wire enable_rise = operate_enable && !en_q;
    wire start_det = operate_enable && en_q && scl_q && serial_clock_line_i &&
        sda_q && !serial_data_line_i;
    wire spurious_start = enable_rise && serial_clock_line_i &&
        !serial_data_line_i;
    wire any_start = start_det || spurious_start;
    wire stop_det = operate_enable && en_q && scl_q && serial_clock_line_i &&
        !sda_q && serial_data_line_i;
    wire scl_rise = !scl_q && serial_clock_line_i;
    wire scl_fall = scl_q && !serial_clock_line_i;
    wire exit_wr = wr && hit(paddr, `I2CEBC_MAIN_CTRL) &&
        pwdata[`I2CEBC_EXIT_BIT];
    wire strt_wr = wr && hit(paddr, `I2CEBC_MAIN_CTRL) &&
        pwdata[`I2CEBC_STRT_BIT] && operate_enable;
    wire stop_wr = wr && hit(paddr, `I2CEBC_MAIN_CTRL) &&
        pwdata[`I2CEBC_STOP_BIT] && operate_enable;
    wire start_refused = strt_wr && (bus_occupied_flag || m_state != M_IDLE);
    wire ack_begin = (s_state == S_ACK) && scl_fall && !exit_wr;

    wire [`I2CEBC_EV_W-1:0] events;
    assign events[`I2CEBC_EV_START] = any_start;
    // Stop event gated by the SPIE bit so stops stay quiet unless it is set
    assign events[`I2CEBC_EV_STOP] = stop_det &&
        main_control_reg[`I2CEBC_SPIE_BIT];
    assign events[`I2CEBC_EV_REFUSE] = start_refused;
    assign events[`I2CEBC_EV_ACK] = ack_begin;

    i2cebc_clkdiv #(
        .BASE(DIV_BASE)
    ) u_div (
        .clk(clk),
        .sys_rst(sys_rst),
        .run(m_state != M_IDLE && m_state != M_HOLD),
        .sel(clk_sel),
        .tick(tick)
    );

    // APB slave: one wait cycle, pready in the second access cycle
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped(paddr);
            prdata <= 32'h00000000;
            if (psel && penable && !pready && !pwrite) begin
                case (paddr)
                    `I2CEBC_MAIN_CTRL: prdata <= {24'h000000,
                        main_control_reg};
                    `I2CEBC_FLAG: prdata <= {24'h000000,
                        flag_reg[7], bus_occupied_flag, flag_reg[5:0]};
                    `I2CEBC_CLK_SEL: prdata <= {28'h0000000, clk_sel[2], 1'b0,
                        clk_sel[1:0]};
                    `I2CEBC_EXT: prdata <= {31'h00000000, clk_sel[3]};
                    `I2CEBC_STATUS: prdata <= {28'h0000000, status};
                    `I2CEBC_MASK: prdata <= {28'h0000000, mask};
                    `I2CEBC_LINES: prdata <= {24'h000000, m_state, 1'b0,
                        s_state, serial_clock_line_i, serial_data_line_i};
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // Control registers
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            main_control_reg <= `I2CEBC_CTRL_RST;
            flag_reg <= `I2CEBC_FLAG_RST;
            clk_sel <= `I2CEBC_CSEL_RST;
            mask <= {`I2CEBC_EV_W{1'b0}};
        end else begin
            if (wr && hit(paddr, `I2CEBC_MAIN_CTRL)) begin
                main_control_reg[7] <= pwdata[7];
                main_control_reg[5:2] <= pwdata[5:2];
            end
            // Triggers self-clear: start and stop read back set for one cycle only, exit never
            main_control_reg[`I2CEBC_EXIT_BIT] <= 1'b0;
            main_control_reg[`I2CEBC_STRT_BIT] <= strt_wr && !start_refused;
            main_control_reg[`I2CEBC_STOP_BIT] <= stop_wr;
            // Flag, clock select and extension frozen while running; stale values stay in force
            if (wr && hit(paddr, `I2CEBC_FLAG) && !operate_enable) begin
                flag_reg[`I2CEBC_STWS_BIT] <= pwdata[`I2CEBC_STWS_BIT];
                flag_reg[`I2CEBC_RSVD_BIT] <= pwdata[`I2CEBC_RSVD_BIT];
            end
            if (wr && hit(paddr, `I2CEBC_CLK_SEL) && !operate_enable) begin
                clk_sel[2] <= pwdata[`I2CEBC_SMC_BIT];
                clk_sel[1] <= pwdata[`I2CEBC_CLH_BIT];
                clk_sel[0] <= pwdata[`I2CEBC_CLL_BIT];
            end
            if (wr && hit(paddr, `I2CEBC_EXT) && !operate_enable)
                clk_sel[3] <= pwdata[`I2CEBC_CLX_BIT];
            if (wr && hit(paddr, `I2CEBC_MASK))
                mask <= pwdata[`I2CEBC_EV_W-1:0];
        end
    end

    // Sticky status; a new event wins over a write-one clear
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            status <= {`I2CEBC_EV_W{1'b0}};
            irq <= 1'b0;
        end else begin
            if (wr && hit(paddr, `I2CEBC_STATUS))
                status <= (status & ~pwdata[`I2CEBC_EV_W-1:0]) | events;
            else
                status <= status | events;
            irq <= |(status & mask);
        end
    end

    // Bus occupancy tracking
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bus_occupied_flag <= 1'b0;
            en_q <= 1'b0;
            sda_q <= 1'b1;
            scl_q <= 1'b1;
        end else begin
            en_q <= operate_enable;
            sda_q <= serial_data_line_i;
            scl_q <= serial_clock_line_i;
            if (!operate_enable)
                bus_occupied_flag <= 1'b0;
            else if (enable_rise)
                bus_occupied_flag <= !start_without_stop_permit;
            else if (stop_det)
                bus_occupied_flag <= 1'b0;
            else if (start_det)
                bus_occupied_flag <= 1'b1;
        end
    end

    // Slave side: watch the first byte after any start seen while the master side is idle
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_state <= S_IDLE;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            serial_data_line_oe <= 1'b0;
            serial_data_line_o <= 1'b0;
        end else if (!operate_enable || stop_det) begin
            s_state <= S_IDLE;
            serial_data_line_oe <= (m_state == M_STOP1) && operate_enable;
        end else if (exit_wr) begin
            s_state <= S_EXIT;
            if (m_state == M_IDLE)
                serial_data_line_oe <= 1'b0;
        end else if (any_start && m_state == M_IDLE) begin
            s_state <= S_RX;
            bit_cnt <= 4'h0;
            serial_data_line_oe <= 1'b0;
        end else begin
            case (s_state)
                S_RX: begin
                    if (scl_rise) begin
                        shift <= {shift[6:0], serial_data_line_i};
                        bit_cnt <= bit_cnt + 4'h1;
                        if (bit_cnt == 4'h7) begin
                            if (shift[6:2] == `I2CEBC_EXT_CODE)
                                s_state <= S_ACK;
                            else
                                s_state <= S_EXIT;
                        end
                    end
                end
                S_ACK: begin
                    if (ack_begin)
                        serial_data_line_oe <= 1'b1;
                    else if (scl_fall && serial_data_line_oe) begin
                        serial_data_line_oe <= 1'b0;
                        s_state <= S_EXIT;
                    end
                end
                S_EXIT: s_state <= S_EXIT;
                default: s_state <= S_IDLE;
            endcase
            if (m_state == M_START || m_state == M_HOLD)
                serial_data_line_oe <= 1'b1;
            else if (m_state == M_STOP1)
                serial_data_line_oe <= 1'b1;
            else if (m_state == M_STOP2 && tick)
                serial_data_line_oe <= 1'b0;
        end
    end

    // Master side: start only on a free bus, stop taken from idle or hold
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            m_state <= M_IDLE;
            serial_clock_line_oe <= 1'b0;
            serial_clock_line_o <= 1'b0;
        end else if (!operate_enable) begin
            m_state <= M_IDLE;
            serial_clock_line_oe <= 1'b0;
        end else begin
            case (m_state)
                M_IDLE: begin
                    if (stop_wr)
                        m_state <= M_STOP1;
                    else if (strt_wr && !start_refused)
                        m_state <= M_START;
                end
                M_START: begin
                    if (tick) begin
                        serial_clock_line_oe <= 1'b1;
                        m_state <= M_HOLD;
                    end
                end
                M_HOLD: begin
                    if (stop_wr)
                        m_state <= M_STOP1;
                end
                M_STOP1: begin
                    if (tick) begin
                        serial_clock_line_oe <= 1'b0;
                        m_state <= M_STOP2;
                    end
                end
                M_STOP2: begin
                    if (tick)
                        m_state <= M_IDLE;
                end
                default: m_state <= M_IDLE;
            endcase
        end
    end
endmodule // i2cebc_ctrl
`default_nettype wire

//--- testbench/i2cebc_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
module i2cebc_ctrl_checker (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq,
    input wire logic serial_data_line_i,
    input wire logic serial_data_line_o,
    input wire logic serial_data_line_oe,
    input wire logic serial_clock_line_i,
    input wire logic serial_clock_line_o,
    input wire logic serial_clock_line_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence acc_start;
        psel && penable && !$past(penable);
    endsequence
    sequence ack_begin;
        $rose(serial_data_line_oe) && !serial_clock_line_i && !serial_clock_line_oe;
    endsequence
    pready_answer_a: assert property (acc_start |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    pready_inside_a: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    unmapped_err_a: assert property (pready && paddr > 8'h18 |-> pslverr)
        else $error("unmapped access without error");
    mapped_ok_a: assert property (pready && paddr <= 8'h18 && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("mapped access flagged as error");
    upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    err_data_a: assert property (pslverr |-> pready && prdata == 32'h00000000)
        else $error("error response malformed");
    drive_low_a: assert property (!serial_data_line_o && !serial_clock_line_o)
        else $error("open drain line driven high");
    ack_hold_a: assert property (ack_begin |=> serial_data_line_oe [*8])
        else $error("acknowledge dropped early");
    reset_idle_a: assert property ($fell(sys_rst) |->
        !irq && !serial_data_line_oe && !serial_clock_line_oe)
        else $error("outputs active after reset");
    // Clock may only be pulled once data is already low, or a stop is faked
    start_order_a: assert property ($rose(serial_clock_line_oe) |-> serial_data_line_oe)
        else $error("clock pulled before data on start");
endmodule // i2cebc_ctrl_checker
bind i2cebc_ctrl i2cebc_ctrl_checker u_chk (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .serial_data_line_i(serial_data_line_i),
    .serial_data_line_o(serial_data_line_o), .serial_data_line_oe(serial_data_line_oe),
    .serial_clock_line_i(serial_clock_line_i), .serial_clock_line_o(serial_clock_line_o),
    .serial_clock_line_oe(serial_clock_line_oe));
`default_nettype wire

//--- testbench/i2cebc_bus_peer.sv
`timescale 1ns/1ps
`default_nettype none
// Another party on the shared bus; lines idle high through the pull-ups
module i2cebc_bus_peer (
    input wire logic clk,
    input wire logic sda,
    output logic sda_low,
    output logic scl_low
);
    initial begin
        sda_low = 1'b0;
        scl_low = 1'b0;
    end
    task automatic half;
        repeat (20) @(posedge clk);
    endtask
    // Data low with clock high: a transfer already under way
    task automatic hold_start;
        sda_low <= 1'b1;
        half();
    endtask
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            scl_low <= 1'b1;
            half();
            sda_low <= !b[i];
            half();
            scl_low <= 1'b0;
            half();
        end
        scl_low <= 1'b1;
        half();
        sda_low <= 1'b0;
        half();
        scl_low <= 1'b0;
        half();
        ack = !sda;
        scl_low <= 1'b1;
        half();
    endtask
    task automatic stop;
        sda_low <= 1'b1;
        half();
        scl_low <= 1'b0;
        half();
        sda_low <= 1'b0;
        half();
    endtask
endmodule // i2cebc_bus_peer
`default_nettype wire

//--- testbench/test_i2c_enable_bus_state_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "i2cebc_map.vh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module test_i2c_enable_bus_state_control;
    logic clk, sys_rst, psel, penable, pwrite, irq, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic sda_oe, scl_oe, p_sda_low, p_scl_low, e, ack;
    wire logic sda = !(sda_oe | p_sda_low);
    wire logic scl = !(scl_oe | p_scl_low);
    int err_count = 0, cmp_count = 0, cyc = 0;
    i2cebc_ctrl #(.DIV_BASE(16'h0004)) u_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .serial_data_line_i(sda),
        .serial_data_line_o(), .serial_data_line_oe(sda_oe), .serial_clock_line_i(scl),
        .serial_clock_line_o(), .serial_clock_line_oe(scl_oe));
    i2cebc_bus_peer u_peer (.clk(clk), .sda(sda), .sda_low(p_sda_low), .scl_low(p_scl_low));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        `CHK(q, exp)
    endtask
    task automatic wait_start;
        for (int i = 0; i < 20 && q[0] !== 1'b1; i++) apb(1'b0, `I2CEBC_STATUS, 32'h0);
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            err_count++;
            stop_test();
        end
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        sys_rst = 1'b1;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        rd_chk(`I2CEBC_MAIN_CTRL, 32'h00000000);
        rd_chk(`I2CEBC_FLAG, 32'h00000000);
        rd_chk(8'h40, 32'h00000000);
        `CHK(e, 1'b1)
        $display("test reset done");
        apb(1'b1, `I2CEBC_CLK_SEL, 32'h0000000B);
        apb(1'b1, `I2CEBC_EXT, 32'h00000001);
        rd_chk(`I2CEBC_CLK_SEL, 32'h0000000B);
        rd_chk(`I2CEBC_EXT, 32'h00000001);
        apb(1'b1, `I2CEBC_FLAG, 32'h00000000);
        apb(1'b1, `I2CEBC_MASK, 32'h00000007);
        apb(1'b1, `I2CEBC_MAIN_CTRL, 32'h00000080);
        rd_chk(`I2CEBC_FLAG, 32'h00000040);
        apb(1'b1, `I2CEBC_CLK_SEL, 32'h00000000);
        rd_chk(`I2CEBC_CLK_SEL, 32'h0000000B);
        apb(1'b1, `I2CEBC_MAIN_CTRL, 32'h00000082);
        rd_chk(`I2CEBC_STATUS, 32'h00000004);
        `CHK(irq, 1'b1)
        apb(1'b1, `I2CEBC_STATUS, 32'h00000004);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0)
        apb(1'b1, `I2CEBC_MAIN_CTRL, 32'h00000081);
        repeat (300) @(posedge clk);
        rd_chk(`I2CEBC_FLAG, 32'h00000000);
        rd_chk(`I2CEBC_STATUS, 32'h00000001);
        apb(1'b1, `I2CEBC_MAIN_CTRL, 32'h00000000);
        $display("test occupied done");
        apb(1'b1, `I2CEBC_FLAG, 32'h00000002);
        apb(1'b1, `I2CEBC_MAIN_CTRL, 32'h00000080);
        rd_chk(`I2CEBC_FLAG, 32'h00000002);
        apb(1'b1, `I2CEBC_MAIN_CTRL, 32'h00000092);
        repeat (20) @(posedge clk);
        rd_chk(`I2CEBC_LINES, 32'h00000040);
        rd_chk(`I2CEBC_FLAG, 32'h00000042);
        apb(1'b1, `I2CEBC_MAIN_CTRL, 32'h00000091);
        repeat (20) @(posedge clk);
        rd_chk(`I2CEBC_LINES, 32'h00000003);
        rd_chk(`I2CEBC_FLAG, 32'h00000002);
        rd_chk(`I2CEBC_STATUS, 32'h00000003);
        apb(1'b1, `I2CEBC_MAIN_CTRL, 32'h00000000);
        $display("test permit done");
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, `I2CEBC_STATUS, 32'h000000FF);
            u_peer.hold_start();
            apb(1'b1, `I2CEBC_MAIN_CTRL, 32'h00000080);
            q = 32'h0;
            wait_start();
            `CHK(q[0], 1'b1)
            if (k == 1)
                apb(1'b1, `I2CEBC_MAIN_CTRL, 32'h000000C0);
            u_peer.send_byte(8'hF0, ack);
            `CHK(ack, k == 0)
            u_peer.stop();
            apb(1'b1, `I2CEBC_MAIN_CTRL, 32'h00000000);
            $display("test join %0d done", k);
        end
        stop_test();
    end
endmodule // test_i2c_enable_bus_state_control
`default_nettype wire
